// [rtl/l4m_pkg.sv]
// l4m_pkg: offsets, field positions, encodings, reset values and carrier types
// for the single access_control_entry matcher; shared by all design files.
package l4m_pkg;
    // register byte offsets (one aligned 32-bit word each)
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_SPMODE = 8'h04;
    localparam logic [7:0] OFS_SPBND  = 8'h08;
    localparam logic [7:0] OFS_DPMODE = 8'h0c;
    localparam logic [7:0] OFS_DPBND  = 8'h10;
    localparam logic [7:0] OFS_FLAGS  = 8'h14;
    localparam logic [7:0] OFS_ETYPE  = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1c;
    localparam logic [7:0] OFS_HITS   = 8'h20;
    // field positions
    localparam int CTRL_EN   = 0;
    localparam int CTRL_FT   = 1;
    localparam int CTRL_PS   = 3;
    localparam int CTRL_ES   = 5;
    localparam int BND_LO    = 0;
    localparam int BND_HI    = 16;
    localparam int ST_HIT    = 0;
    localparam int ST_EBAD   = 1;
    localparam int ST_SPBAD  = 2;
    localparam int ST_DPBAD  = 3;
    localparam int ST_SEEN   = 4;
    localparam int F_FIN     = 0;
    localparam int F_SYN     = 1;
    localparam int F_RST     = 2;
    localparam int F_PSH     = 3;
    localparam int F_ACK     = 4;
    localparam int F_URG     = 5;
    localparam int NFLAGS    = 6;
    // port criterion modes
    localparam logic [1:0] PM_ANY   = 2'h0;
    localparam logic [1:0] PM_EXACT = 2'h1;
    localparam logic [1:0] PM_RANGE = 2'h2;
    // flag criterion settings, two bits per flag
    localparam logic [1:0] FC_CLEAR = 2'h0;
    localparam logic [1:0] FC_SET   = 2'h1;
    localparam logic [1:0] FC_ANY   = 2'h2;
    // frame type and protocol selections
    localparam logic [1:0] FT_ANY   = 2'h0;
    localparam logic [1:0] FT_ETYPE = 2'h1;
    localparam logic [1:0] FT_IPV4  = 2'h2;
    localparam logic [1:0] PS_ANY   = 2'h0;
    localparam logic [1:0] PS_TCP   = 2'h1;
    localparam logic [1:0] PS_UDP   = 2'h2;
    localparam logic [7:0] IP_TCP   = 8'h06;
    localparam logic [7:0] IP_UDP   = 8'h11;
    // ethertype limits and codes owned by other frame types, then the flag criteria reset value
    localparam logic [15:0] ET_MIN  = 16'h0600;
    localparam logic [15:0] ET_IPV4 = 16'h0800;
    localparam logic [15:0] ET_ARP  = 16'h0806;
    localparam logic [15:0] ET_IPV6 = 16'h86dd;
    localparam logic [11:0] FLAGS_RST = 12'haaa;

    typedef struct packed {
        logic [15:0] etype;
        logic        is_ipv4;
        logic [7:0]  ip_proto;
        logic [15:0] src_port;
        logic [15:0] dst_port;
        logic [5:0]  tcp_flags;
    } l4m_frame_t;

    typedef struct packed {
        logic        enable;
        logic [1:0]  ftype;
        logic [1:0]  proto;
        logic        etype_spec;
        logic [1:0]  sp_mode;
        logic [15:0] sp_lo;
        logic [15:0] sp_hi;
        logic [1:0]  dp_mode;
        logic [15:0] dp_lo;
        logic [15:0] dp_hi;
        logic [11:0] flags;
        logic [15:0] etype;
    } l4m_cfg_t;

    localparam l4m_cfg_t CFG_RST = '{enable: 1'b0, ftype: FT_ANY, proto: PS_ANY,
        etype_spec: 1'b0, sp_mode: PM_ANY, sp_lo: 16'h0000, sp_hi: 16'h0000,
        dp_mode: PM_ANY, dp_lo: 16'h0000, dp_hi: 16'h0000, flags: FLAGS_RST,
        etype: 16'h0000};

    // one flag against its three-way setting
    function automatic logic l4m_flag_ok(input logic [1:0] crit, input logic f);
        if (crit == FC_CLEAR) begin
            return !f;
        end
        if (crit == FC_SET) begin
            return f;
        end
        return 1'b1;
    endfunction : l4m_flag_ok
endpackage : l4m_pkg

// [rtl/l4m_port_match.sv]
// l4m_port_match: one transport port against a don't-care, exact or range test.
// assumes a purely combinational use inside the matcher.
`timescale 1ns/1ps
`default_nettype none
module l4m_port_match
    import l4m_pkg::*;
(
    // criterion
    input  wire logic [1:0]  mode_in,
    input  wire logic [15:0] lo_in,
    input  wire logic [15:0] hi_in,
    // frame field
    input  wire logic [15:0] port_in,
    // result
    output logic             match_out,
    output logic             bad_range_out
);
    // bounds compare unsigned and inclusive; reversed bounds never hit in range mode
    always_comb begin
        bad_range_out = (lo_in > hi_in);
        case (mode_in)
            PM_ANY:   match_out = 1'b1;
            PM_EXACT: match_out = (port_in == lo_in);
            PM_RANGE: match_out = !bad_range_out
                               && (port_in >= lo_in) && (port_in <= hi_in);
            default:  match_out = 1'b0; // reserved mode is a miss, safer than a hit
        endcase
    end
endmodule : l4m_port_match
`default_nettype wire

// [rtl/l4m_flag_match.sv]
// l4m_flag_match: the six tcp control flags against their three-way settings.
// assumes the caller decides whether the frame is tcp at all.
`timescale 1ns/1ps
`default_nettype none
module l4m_flag_match
    import l4m_pkg::*;
(
    // criteria, two bits per flag
    input  wire logic [11:0] crit_in,
    // frame flags
    input  wire logic [5:0]  flags_in,
    // result
    output logic             match_out,
    output logic             active_out
);
    // every flag must agree; active when any setting is not don't-care
    always_comb begin
        match_out  = 1'b1;
        active_out = 1'b0;
        for (int i = 0; i < NFLAGS; i++) begin
            match_out  = match_out & l4m_flag_ok(crit_in[2*i +: 2], flags_in[i]);
            // codes 2 and 3 both mean don't-care, so only clear and set arm the test
            active_out = active_out | (crit_in[2*i +: 2] == FC_CLEAR)
                                    | (crit_in[2*i +: 2] == FC_SET);
        end
    end
endmodule : l4m_flag_match
`default_nettype wire

// [rtl/l4m_entry_matcher.sv]
// l4m_entry_matcher: decides whether each received frame hits one access_control_entry.
// assumes the receive parser presents one parsed frame per frame_valid_in cycle on this
// clock, and software writes the criteria over a plain one-cycle register port.
`timescale 1ns/1ps
`default_nettype none
module l4m_entry_matcher
    import l4m_pkg::*;
(
    // clock and reset
    input  wire logic        core_clk_in,
    input  wire logic        rst_in,
    // register port
    input  wire logic [7:0]  addr_in,
    input  wire logic [31:0] wdata_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    output logic [31:0]      rdata_out,
    // parsed frame from the receive path
    input  wire logic        frame_valid_in,
    input  wire l4m_frame_t  frame_in,
    // decision, one cycle after the frame
    output logic             hit_valid_out,
    output logic             hit_out
);
    l4m_cfg_t    cfg;
    logic [31:0] hit_count;
    logic        seen;
    logic        sp_match;
    logic        sp_bad;
    logic        dp_match;
    logic        dp_bad;
    logic        fl_match;
    logic        fl_active;
    logic        is_tcp;
    logic        is_udp;
    logic        l4_ok;
    logic        etype_bad;
    logic        sp_ok;
    logic        dp_ok;
    logic        fl_ok;
    logic        type_ok;
    logic        proto_ok;
    logic        next_hit;
    logic [31:0] next_rdata;

    // source and destination port tests
    l4m_port_match u_src (
        .mode_in       (cfg.sp_mode),
        .lo_in         (cfg.sp_lo),
        .hi_in         (cfg.sp_hi),
        .port_in       (frame_in.src_port),
        .match_out     (sp_match),
        .bad_range_out (sp_bad)
    );

    l4m_port_match u_dst (
        .mode_in       (cfg.dp_mode),
        .lo_in         (cfg.dp_lo),
        .hi_in         (cfg.dp_hi),
        .port_in       (frame_in.dst_port),
        .match_out     (dp_match),
        .bad_range_out (dp_bad)
    );

    // tcp control flag tests
    l4m_flag_match u_flags (
        .crit_in    (cfg.flags),
        .flags_in   (frame_in.tcp_flags),
        .match_out  (fl_match),
        .active_out (fl_active)
    );

    // transport classification of the incoming frame
    assign is_tcp = frame_in.is_ipv4 && (frame_in.ip_proto == IP_TCP);
    assign is_udp = frame_in.is_ipv4 && (frame_in.ip_proto == IP_UDP);
    assign l4_ok  = is_tcp || is_udp;

    // an out-of-span or reserved ethertype can never hit
    assign etype_bad = (cfg.etype < ET_MIN) || (cfg.etype == ET_IPV4)
                    || (cfg.etype == ET_ARP) || (cfg.etype == ET_IPV6);

    // port tests count only on ipv4 tcp or udp frames
    assign sp_ok = (cfg.sp_mode == PM_ANY) || (l4_ok && sp_match);
    assign dp_ok = (cfg.dp_mode == PM_ANY) || (l4_ok && dp_match);
    // flag tests only see tcp frames
    assign fl_ok = !fl_active || (is_tcp && fl_match);

    // frame type selection; the ethertype compare sits only in its own class
    always_comb begin
        case (cfg.ftype)
            FT_ANY:   type_ok = 1'b1;
            FT_ETYPE: type_ok = !cfg.etype_spec
                             || (!etype_bad && frame_in.etype == cfg.etype);
            FT_IPV4:  type_ok = frame_in.is_ipv4;
            default:  type_ok = 1'b0;
        endcase
    end

    // protocol selection
    always_comb begin
        case (cfg.proto)
            PS_ANY:  proto_ok = 1'b1;
            PS_TCP:  proto_ok = is_tcp;
            PS_UDP:  proto_ok = is_udp;
            default: proto_ok = 1'b0;
        endcase
    end

    // all criteria at once; a disabled entry never hits
    assign next_hit = cfg.enable && sp_ok && dp_ok && fl_ok
                   && type_ok && proto_ok;

    // decision register; one frame in, one answer out a cycle later
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            hit_valid_out <= 1'b0;
            hit_out       <= 1'b0;
        end else begin
            hit_valid_out <= frame_valid_in;
            hit_out       <= frame_valid_in && next_hit;
        end
    end

    // status: seen stays set once any frame was judged
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            seen <= 1'b0;
        end else if (hit_valid_out) begin
            seen <= 1'b1;
        end
    end

    // hit counter; a hit in the clearing cycle is kept by restarting at one
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            hit_count <= 32'h0000_0000;
        end else if (wr_in && addr_in == OFS_HITS) begin
            hit_count <= {31'h0000_0000, hit_valid_out & hit_out};
        end else if (hit_valid_out && hit_out) begin
            hit_count <= hit_count + 32'h0000_0001;
        end
    end

    // configuration writes
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            cfg <= CFG_RST;
        end else if (wr_in) begin
            case (addr_in)
                OFS_CTRL: begin
                    cfg.enable     <= wdata_in[CTRL_EN];
                    cfg.ftype      <= wdata_in[CTRL_FT +: 2];
                    cfg.proto      <= wdata_in[CTRL_PS +: 2];
                    cfg.etype_spec <= wdata_in[CTRL_ES];
                end
                OFS_SPMODE: cfg.sp_mode <= wdata_in[1:0];
                OFS_SPBND: begin
                    cfg.sp_lo <= wdata_in[BND_LO +: 16];
                    cfg.sp_hi <= wdata_in[BND_HI +: 16];
                end
                OFS_DPMODE: cfg.dp_mode <= wdata_in[1:0];
                OFS_DPBND: begin
                    cfg.dp_lo <= wdata_in[BND_LO +: 16];
                    cfg.dp_hi <= wdata_in[BND_HI +: 16];
                end
                OFS_FLAGS: cfg.flags <= wdata_in[11:0];
                OFS_ETYPE: cfg.etype <= wdata_in[15:0];
                default: ;
            endcase
        end
    end

    // read mux; unmapped offsets read zero
    always_comb begin
        next_rdata = 32'h0000_0000;
        case (addr_in)
            OFS_CTRL: begin
                next_rdata[CTRL_EN]      = cfg.enable;
                next_rdata[CTRL_FT +: 2] = cfg.ftype;
                next_rdata[CTRL_PS +: 2] = cfg.proto;
                next_rdata[CTRL_ES]      = cfg.etype_spec;
            end
            OFS_SPMODE: next_rdata[1:0] = cfg.sp_mode;
            OFS_SPBND:  next_rdata = {cfg.sp_hi, cfg.sp_lo};
            OFS_DPMODE: next_rdata[1:0] = cfg.dp_mode;
            OFS_DPBND:  next_rdata = {cfg.dp_hi, cfg.dp_lo};
            OFS_FLAGS:  next_rdata[11:0] = cfg.flags;
            OFS_ETYPE:  next_rdata[15:0] = cfg.etype;
            OFS_STATUS: begin
                next_rdata[ST_HIT]   = hit_out;
                next_rdata[ST_EBAD]  = etype_bad;
                next_rdata[ST_SPBAD] = sp_bad;
                next_rdata[ST_DPBAD] = dp_bad;
                next_rdata[ST_SEEN]  = seen;
            end
            OFS_HITS:   next_rdata = hit_count;
            default:    next_rdata = 32'h0000_0000;
        endcase
    end

    // read data stands only in the cycle after the strobe, zero elsewhere
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            rdata_out <= 32'h0000_0000;
        end else begin
            rdata_out <= rd_in ? next_rdata : 32'h0000_0000;
        end
    end

    // checks on the decision path
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (rst_in);

    sequence s_frame;
        frame_valid_in && cfg.enable;
    endsequence

    sequence s_miss;
        hit_valid_out && !hit_out;
    endsequence

    sequence s_hit;
        hit_valid_out && hit_out;
    endsequence

    a_answer_latency: assert property (
        frame_valid_in |=> hit_valid_out ##1 (hit_valid_out == $past(frame_valid_in)))
        else $error("decision not one cycle after frame");

    a_all_dontcare: assert property (
        s_frame ##0 (cfg.sp_mode == PM_ANY && cfg.dp_mode == PM_ANY && !fl_active
            && cfg.ftype == FT_ANY && cfg.proto == PS_ANY) |=> s_hit)
        else $error("don't-care entry missed a frame");

    a_sport_exact: assert property (
        s_frame ##0 (cfg.sp_mode == PM_EXACT && frame_in.src_port != cfg.sp_lo)
        |=> s_miss)
        else $error("source port exact mismatch hit");

    a_sport_range: assert property (
        s_frame ##0 (cfg.sp_mode == PM_RANGE && (frame_in.src_port < cfg.sp_lo
            || frame_in.src_port > cfg.sp_hi)) |=> s_miss)
        else $error("source port outside range hit");

    a_dport_exact: assert property (
        s_frame ##0 (cfg.dp_mode == PM_EXACT && frame_in.dst_port != cfg.dp_lo)
        |=> s_miss)
        else $error("destination port exact mismatch hit");

    a_dport_range: assert property (
        s_frame ##0 (cfg.dp_mode == PM_RANGE && (frame_in.dst_port < cfg.dp_lo
            || frame_in.dst_port > cfg.dp_hi)) |=> s_miss)
        else $error("destination port outside range hit");

    a_dport_free: assert property (
        s_frame ##0 (cfg.dp_mode == PM_ANY && cfg.sp_mode == PM_ANY && !fl_active
            && cfg.ftype == FT_IPV4 && cfg.proto == PS_TCP && is_tcp) |=> s_hit)
        else $error("destination don't-care changed the decision");

    a_fin_flag: assert property (
        s_frame ##0 (!l4m_flag_ok(cfg.flags[2*F_FIN +: 2], frame_in.tcp_flags[F_FIN]))
        |=> s_miss)
        else $error("fin setting violated yet hit");

    a_syn_flag: assert property (
        s_frame ##0 (!l4m_flag_ok(cfg.flags[2*F_SYN +: 2], frame_in.tcp_flags[F_SYN]))
        |=> s_miss)
        else $error("syn setting violated yet hit");

    a_rst_flag: assert property (
        s_frame ##0 (!l4m_flag_ok(cfg.flags[2*F_RST +: 2], frame_in.tcp_flags[F_RST]))
        |=> s_miss)
        else $error("rst setting violated yet hit");

    a_psh_flag: assert property (
        s_frame ##0 (!l4m_flag_ok(cfg.flags[2*F_PSH +: 2], frame_in.tcp_flags[F_PSH]))
        |=> s_miss)
        else $error("psh setting violated yet hit");

    a_ack_flag: assert property (
        s_frame ##0 (!l4m_flag_ok(cfg.flags[2*F_ACK +: 2], frame_in.tcp_flags[F_ACK]))
        |=> s_miss)
        else $error("ack setting violated yet hit");

    a_urg_flag: assert property (
        s_frame ##0 (!l4m_flag_ok(cfg.flags[2*F_URG +: 2], frame_in.tcp_flags[F_URG]))
        |=> s_miss)
        else $error("urg setting violated yet hit");

    a_flags_need_tcp: assert property (
        s_frame ##0 (fl_active && !is_tcp) |=> s_miss)
        else $error("flag test hit a non-tcp frame");

    a_etype_exact: assert property (
        s_frame ##0 (cfg.ftype == FT_ETYPE && cfg.etype_spec
            && frame_in.etype != cfg.etype) |=> s_miss)
        else $error("ethertype mismatch hit");

    a_etype_unused: assert property (
        s_frame ##0 (cfg.ftype == FT_IPV4 && cfg.etype_spec && cfg.proto == PS_TCP && is_tcp
            && cfg.sp_mode == PM_ANY && cfg.dp_mode == PM_ANY && !fl_active) |=> s_hit)
        else $error("ethertype compare outside its class");

    a_range_reversed: assert property (
        s_frame ##0 ((cfg.sp_mode == PM_RANGE && cfg.sp_lo > cfg.sp_hi)
            || (cfg.dp_mode == PM_RANGE && cfg.dp_lo > cfg.dp_hi)) |=> s_miss)
        else $error("reversed range bounds hit");

    a_disabled_miss: assert property (
        frame_valid_in && !cfg.enable |=> s_miss)
        else $error("disabled entry hit");

    // no frame, no decision: a stray strobe would be counted as a hit
    a_idle_quiet: assert property (
        !frame_valid_in |=> !hit_valid_out && !hit_out)
        else $error("decision without a frame");

    a_ports_need_l4: assert property (
        s_frame ##0 ((cfg.sp_mode != PM_ANY || cfg.dp_mode != PM_ANY) && !is_tcp && !is_udp)
        |=> s_miss)
        else $error("port test hit a non-transport frame");
endmodule : l4m_entry_matcher
`default_nettype wire

// [bench/l4m_rx_model.sv]
// l4m_rx_model: stand-in for the receive parser that feeds parsed frames to the matcher.
// assumes one send pulse per frame from the bench, on the matcher's clock.
`timescale 1ns/1ps
`default_nettype none
module l4m_rx_model
    import l4m_pkg::*;
(
    // clock and reset
    input  wire logic       core_clk_in,
    input  wire logic       rst_in,
    // request from the bench
    input  wire logic       send_in,
    input  wire l4m_frame_t frm_in,
    // parsed frame towards the matcher
    output logic            frame_valid_out,
    output l4m_frame_t      frame_out
);
    // one valid cycle per frame; fields toggle between frames so stale data never passes
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            frame_valid_out <= 1'b0;
            frame_out       <= '0;
        end else if (send_in) begin
            frame_valid_out <= 1'b1;
            frame_out       <= frm_in;
        end else begin
            frame_valid_out <= 1'b0;
            frame_out       <= ~frame_out;
        end
    end
endmodule : l4m_rx_model
`default_nettype wire

// [bench/testbench.sv]
// testbench: register and frame-path checks for the entry matcher.
// assumes the rx model supplies frames and the bench plays software.
`timescale 1ns/1ps
`default_nettype none
module testbench
    import l4m_pkg::*;
;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        send_req = 1'b0;
    l4m_frame_t  frm = '0;
    logic [31:0] rdata;
    logic        fvalid;
    l4m_frame_t  fdata;
    logic        hvalid;
    logic        hit;
    int          n_mismatch = 0;
    int          n_tests = 0;
    int          n_hits = 0;
    logic [11:0] fl;
    logic        v;
    logic [15:0] ets [6] = '{16'h0600, 16'hffff, 16'h05ff, ET_IPV4, ET_ARP, ET_IPV6};

    // 10 mhz core clock
    initial begin
        forever #50 clk = ~clk;
    end

    l4m_rx_model i_l4m_rx_model (.core_clk_in(clk), .rst_in(rst), .send_in(send_req),
        .frm_in(frm), .frame_valid_out(fvalid), .frame_out(fdata));
    l4m_entry_matcher i_l4m_entry_matcher (.core_clk_in(clk), .rst_in(rst), .addr_in(addr),
        .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .frame_valid_in(fvalid),
        .frame_in(fdata), .hit_valid_out(hvalid), .hit_out(hit));

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : test_done

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] x);
        @(posedge clk);
        addr  <= a;
        wdata <= x;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask : wr_reg

    // read data stands only in the cycle after the strobe, so it is sampled there
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        chk(rdata & m, e, "register read");
    endtask : rd_chk

    task automatic send(input l4m_frame_t f, input logic e);
        int i;
        @(posedge clk);
        frm      <= f;
        send_req <= 1'b1;
        @(posedge clk);
        send_req <= 1'b0;
        for (i = 0; i < 4; i++) begin
            @(posedge clk);
            #1;
            if (hvalid === 1'b1) break;
        end
        if (i == 4) begin
            n_mismatch++;
            $display("MISMATCH at %0t: no decision", $time);
            test_done();
        end
        chk({31'h0, hit}, {31'h0, e}, "hit");
        if (e) n_hits++;
    endtask : send

    function automatic l4m_frame_t mkf(input logic [15:0] sp, input logic [15:0] dp,
                                       input logic [5:0] f, input logic [7:0] pr,
                                       input logic [15:0] et);
        return '{etype: et, is_ipv4: (et == ET_IPV4), ip_proto: pr, src_port: sp,
                 dst_port: dp, tcp_flags: f};
    endfunction : mkf

    function automatic logic [31:0] ctl(input logic [1:0] ft, input logic [1:0] ps,
                                        input logic es);
        return {26'h0, es, ps, ft, 1'b1};
    endfunction : ctl

    // one port criterion on source (s=0) or destination (s=1), other port left open
    task automatic pc(input logic s, input logic [1:0] m, input logic [15:0] lo,
                      input logic [15:0] hi, input logic [15:0] p, input logic e);
        wr_reg(s ? OFS_DPMODE : OFS_SPMODE, {30'h0, m});
        wr_reg(s ? OFS_DPBND : OFS_SPBND, {hi, lo});
        send(s ? mkf(16'h1111, p, 6'h0, IP_TCP, ET_IPV4)
               : mkf(p, 16'h1111, 6'h0, IP_TCP, ET_IPV4), e);
    endtask : pc

    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd_chk(OFS_CTRL, 32'hffffffff, 32'h0);
        rd_chk(OFS_FLAGS, 32'hffffffff, {20'h0, FLAGS_RST});
        // reset ethertype 0x0000 lies below the legal span, so it reads as invalid
        rd_chk(OFS_STATUS, 32'hffffffff, 32'h2);
        rd_chk(8'h40, 32'hffffffff, 32'h0);
        $display("test reset done");
        wr_reg(OFS_CTRL, ctl(FT_IPV4, PS_TCP, 1'b0));
        for (int s = 0; s < 2; s++) begin
            pc(s[0], PM_EXACT, 16'hffff, 16'h0, 16'hffff, 1);
            pc(s[0], PM_EXACT, 16'hffff, 16'h0, 16'hfffe, 0);
            pc(s[0], PM_EXACT, 16'h0, 16'hffff, 16'h0, 1);
            pc(s[0], PM_ANY, 16'h1234, 16'h1234, 16'h4321, 1);
            pc(s[0], PM_RANGE, 16'h0064, 16'h00c8, 16'h0064, 1);
            pc(s[0], PM_RANGE, 16'h0064, 16'h00c8, 16'h00c8, 1);
            pc(s[0], PM_RANGE, 16'h0064, 16'h00c8, 16'h0063, 0);
            pc(s[0], PM_RANGE, 16'h0064, 16'h00c8, 16'h00c9, 0);
            pc(s[0], PM_RANGE, 16'h0, 16'hffff, 16'hffff, 1);
            pc(s[0], 2'h3, 16'h0, 16'hffff, 16'h0, 0);
            pc(s[0], PM_RANGE, 16'h00c8, 16'h0064, 16'h0096, 0);
            rd_chk(OFS_STATUS, 32'h4 << s, 32'h4 << s);
            wr_reg(s[0] ? OFS_DPMODE : OFS_SPMODE, {30'h0, PM_ANY});
            wr_reg(s[0] ? OFS_DPBND : OFS_SPBND, 32'h0);
        end
        $display("test ports done");
        // each flag alone in clear, set and any, with the other five held open
        for (int i = 0; i < NFLAGS; i++) begin
            for (int c = 0; c < 3; c++) begin
                fl = FLAGS_RST;
                fl[2*i +: 2] = c[1:0];
                wr_reg(OFS_FLAGS, {20'h0, fl});
                send(mkf(16'h1, 16'h2, 6'h1 << i, IP_TCP, ET_IPV4), c[1:0] != FC_CLEAR);
                send(mkf(16'h1, 16'h2, ~(6'h1 << i), IP_TCP, ET_IPV4), c[1:0] != FC_SET);
            end
        end
        $display("test flags done");
        wr_reg(OFS_FLAGS, {20'h0, FLAGS_RST & 12'hffc});
        wr_reg(OFS_CTRL, ctl(FT_ANY, PS_ANY, 1'b0));
        send(mkf(16'h1, 16'h2, 6'h0, IP_TCP, ET_IPV4), 1);
        send(mkf(16'h1, 16'h2, 6'h0, IP_UDP, ET_IPV4), 0);
        wr_reg(OFS_FLAGS, {20'h0, FLAGS_RST});
        wr_reg(OFS_SPMODE, {30'h0, PM_EXACT});
        wr_reg(OFS_SPBND, 32'h1);
        send(mkf(16'h1, 16'h2, 6'h0, IP_UDP, ET_IPV4), 1);
        send(mkf(16'h1, 16'h2, 6'h0, IP_UDP, 16'h88b5), 0);
        wr_reg(OFS_CTRL, ctl(FT_IPV4, PS_UDP, 1'b0));
        send(mkf(16'h1, 16'h2, 6'h0, IP_UDP, ET_IPV4), 1);
        send(mkf(16'h1, 16'h2, 6'h0, IP_TCP, ET_IPV4), 0);
        wr_reg(OFS_CTRL, ctl(FT_ANY, PS_ANY, 1'b0));
        wr_reg(OFS_DPMODE, {30'h0, PM_EXACT});
        wr_reg(OFS_DPBND, 32'h3);
        send(mkf(16'h1, 16'h2, 6'h0, IP_TCP, ET_IPV4), 0);
        wr_reg(OFS_DPBND, 32'h2);
        send(mkf(16'h1, 16'h2, 6'h0, IP_TCP, ET_IPV4), 1);
        wr_reg(OFS_CTRL, 32'h0);
        send(mkf(16'h1, 16'h2, 6'h0, IP_TCP, ET_IPV4), 0);
        wr_reg(OFS_SPMODE, 32'h0);
        wr_reg(OFS_DPMODE, 32'h0);
        $display("test combine done");
        wr_reg(OFS_CTRL, ctl(FT_ETYPE, PS_ANY, 1'b1));
        foreach (ets[k]) begin
            wr_reg(OFS_ETYPE, {16'h0, ets[k]});
            v = !(ets[k] < 16'h0600 || ets[k] == 16'h0800 || ets[k] == 16'h0806 ||
                  ets[k] == 16'h86dd);
            rd_chk(OFS_STATUS, 32'h2, {30'h0, !v, 1'b0});
            send(mkf(16'h1, 16'h2, 6'h0, IP_TCP, ets[k]), v);
            send(mkf(16'h1, 16'h2, 6'h0, IP_TCP, ets[k] ^ 16'h1), 0);
        end
        wr_reg(OFS_ETYPE, 32'h0600);
        wr_reg(OFS_CTRL, ctl(FT_ETYPE, PS_ANY, 1'b0));
        send(mkf(16'h1, 16'h2, 6'h0, IP_TCP, 16'h1234), 1);
        wr_reg(OFS_CTRL, ctl(FT_IPV4, PS_TCP, 1'b1));
        send(mkf(16'h1, 16'h2, 6'h0, IP_TCP, ET_IPV4), 1);
        $display("test ethertype done");
        rd_chk(OFS_HITS, 32'hffffffff, n_hits);
        rd_chk(OFS_STATUS, 32'h10, 32'h10);
        wr_reg(OFS_HITS, 32'h0);
        rd_chk(OFS_HITS, 32'hffffffff, 32'h0);
        $display("test counters done");
        test_done();
    end
endmodule : testbench
`default_nettype wire
